// [design/parallel_io_pkg.sv]
// Constants, field layouts and carrier types for the 24-line parallel I/O port.
// Assumes a single 40 MHz clock domain and a host bus that issues one-cycle strobes.
package parallel_io_pkg;

	// Byte offsets within the four-byte window
	localparam logic [1:0] OFS_PORT_A  = 2'h0;
	localparam logic [1:0] OFS_PORT_B  = 2'h1;
	localparam logic [1:0] OFS_PORT_C  = 2'h2;
	localparam logic [1:0] OFS_CONTROL = 2'h3;

	// Reset control word: mode definition, basic mode, every section input
	localparam logic [7:0] CTRL_RESET    = 8'h9B;
	localparam logic [7:0] READ_CONTROL  = 8'h00;
	localparam logic [7:0] LATCH_RESET   = 8'h00;

	// Control word field positions
	localparam int CTRL_DEFINE_BIT = 7;
	localparam int BSR_SEL_MSB     = 3;
	localparam int BSR_SEL_LSB     = 1;
	localparam int BSR_VAL_BIT     = 0;

	// Port C line roles in the strobed and bus modes
	localparam int PC_INTR_B = 0;
	localparam int PC_HS_B   = 1;
	localparam int PC_STB_B  = 2;
	localparam int PC_INTR_A = 3;
	localparam int PC_STB_A  = 4;
	localparam int PC_IBF_A  = 5;
	localparam int PC_ACK_A  = 6;
	localparam int PC_OBF_A  = 7;

	// Interrupt lines on port C upper
	localparam int IRQ_REQ_BIT = 7;
	localparam int IRQ_EN_BIT  = 6;

	typedef enum logic [1:0]
	{
		A_BASIC    = 2'b00,
		A_STROBED  = 2'b01,
		A_BIDIR    = 2'b10
	} a_mode_t;

	// Mode definition word, bit 7 down to bit 0; direction bits: one is input
	typedef struct packed
	{
		logic       define;
		logic [1:0] a_mode;
		logic       a_in;
		logic       cu_in;
		logic       b_mode;
		logic       b_in;
		logic       cl_in;
	} ctrl_word_t;

	// One host bus cycle: rd and wr are single-cycle strobes
	typedef struct packed
	{
		logic       rd;
		logic       wr;
		logic [1:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

endpackage

// [design/parallel_io_port.sv]
// Programmable 24-line parallel I/O port with four byte registers on the host bus.
// Assumes host strobes are synchronous to sys_clk_i; pin inputs are asynchronous.
`timescale 1ns/100ps
`default_nettype none

module parallel_io_port
(
	input  wire logic                      sys_clk_i,
	input  wire logic                      reset_i,
	input  wire parallel_io_pkg::bus_req_t bus_i,
	output logic [7:0]                     rd_data_o,
	output logic                           rd_valid_o,
	input  wire logic [7:0]                pa_i,
	output logic [7:0]                     pa_o,
	output logic [7:0]                     pa_oe_n_o,
	input  wire logic [7:0]                pb_i,
	output logic [7:0]                     pb_o,
	output logic [7:0]                     pb_oe_n_o,
	input  wire logic [7:0]                pc_i,
	output logic [7:0]                     pc_o,
	output logic [7:0]                     pc_oe_n_o,
	output logic                           irq_o,
	output logic                           irq_oe_n_o
);

	parallel_io_pkg::ctrl_word_t ctrl_reg;
	parallel_io_pkg::a_mode_t    a_mode;
	logic [7:0] a_s1_reg, a_s2_reg, b_s1_reg, b_s2_reg;
	logic [7:0] c_s1_reg, c_s2_reg, c_prev_reg;
	logic [7:0] a_out_reg, b_out_reg, a_in_reg, b_in_reg;
	logic [7:0] pc_reg, pc_next;
	logic       inte_a_in_reg, inte_a_out_reg, inte_b_reg;
	logic [7:0] c_drive, c_eff;
	logic       a_drive;
	logic       b_strobed, a_in_hs, a_out_hs, b_in_hs, b_out_hs;
	logic       wr_ctrl, mode_wr, bsr_wr, wr_a, wr_b, wr_c, rd_a, rd_b;
	logic [2:0] bsr_sel;
	logic       bsr_val;
	logic       stb_a_fall, stb_a_rise, ack_a_fall, ack_a_rise, hs_b_fall, hs_b_rise;
	logic [7:0] rd_next;

	// Address decode of the four-byte window
	assign wr_a    = bus_i.wr && bus_i.addr == parallel_io_pkg::OFS_PORT_A;
	assign wr_b    = bus_i.wr && bus_i.addr == parallel_io_pkg::OFS_PORT_B;
	assign wr_c    = bus_i.wr && bus_i.addr == parallel_io_pkg::OFS_PORT_C;
	assign wr_ctrl = bus_i.wr && bus_i.addr == parallel_io_pkg::OFS_CONTROL;
	assign rd_a    = bus_i.rd && bus_i.addr == parallel_io_pkg::OFS_PORT_A;
	assign rd_b    = bus_i.rd && bus_i.addr == parallel_io_pkg::OFS_PORT_B;
	// Bit 7 splits control writes
	assign mode_wr = wr_ctrl && bus_i.wdata[parallel_io_pkg::CTRL_DEFINE_BIT];
	assign bsr_wr  = wr_ctrl && !bus_i.wdata[parallel_io_pkg::CTRL_DEFINE_BIT];
	// Bits 6:4 of a bit-op are don't care
	assign bsr_sel = bus_i.wdata[parallel_io_pkg::BSR_SEL_MSB:parallel_io_pkg::BSR_SEL_LSB];
	assign bsr_val = bus_i.wdata[parallel_io_pkg::BSR_VAL_BIT];

	// Two-stage synchronisers; edge detection only looks at the second stage
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			a_s1_reg   <= 8'hFF;
			a_s2_reg   <= 8'hFF;
			b_s1_reg   <= 8'hFF;
			b_s2_reg   <= 8'hFF;
			c_s1_reg   <= 8'hFF;
			c_s2_reg   <= 8'hFF;
			c_prev_reg <= 8'hFF;
		end
		else
		begin
			a_s1_reg   <= pa_i;
			a_s2_reg   <= a_s1_reg;
			b_s1_reg   <= pb_i;
			b_s2_reg   <= b_s1_reg;
			c_s1_reg   <= pc_i;
			c_s2_reg   <= c_s1_reg;
			c_prev_reg <= c_s2_reg;
		end
	end

	assign stb_a_fall = c_prev_reg[parallel_io_pkg::PC_STB_A] & ~c_s2_reg[parallel_io_pkg::PC_STB_A];
	assign stb_a_rise = ~c_prev_reg[parallel_io_pkg::PC_STB_A] & c_s2_reg[parallel_io_pkg::PC_STB_A];
	assign ack_a_fall = c_prev_reg[parallel_io_pkg::PC_ACK_A] & ~c_s2_reg[parallel_io_pkg::PC_ACK_A];
	assign ack_a_rise = ~c_prev_reg[parallel_io_pkg::PC_ACK_A] & c_s2_reg[parallel_io_pkg::PC_ACK_A];
	assign hs_b_fall  = c_prev_reg[parallel_io_pkg::PC_STB_B] & ~c_s2_reg[parallel_io_pkg::PC_STB_B];
	assign hs_b_rise  = ~c_prev_reg[parallel_io_pkg::PC_STB_B] & c_s2_reg[parallel_io_pkg::PC_STB_B];

	// Control register; reset leaves every section an input
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			ctrl_reg <= parallel_io_pkg::CTRL_RESET;
		else if (mode_wr)
			ctrl_reg <= bus_i.wdata;
	end

	// Mode 11 behaves as the bus mode, as bit 6 alone selects it
	always_comb
	begin
		if (ctrl_reg.a_mode[1])
			a_mode = parallel_io_pkg::A_BIDIR;
		else if (ctrl_reg.a_mode[0])
			a_mode = parallel_io_pkg::A_STROBED;
		else
			a_mode = parallel_io_pkg::A_BASIC;
	end

	// Group roles; bus mode belongs to group A only
	assign b_strobed = ctrl_reg.b_mode;
	assign a_in_hs   = (a_mode == parallel_io_pkg::A_STROBED && ctrl_reg.a_in)
		|| a_mode == parallel_io_pkg::A_BIDIR;
	assign a_out_hs  = (a_mode == parallel_io_pkg::A_STROBED && !ctrl_reg.a_in)
		|| a_mode == parallel_io_pkg::A_BIDIR;
	assign b_in_hs   = b_strobed && ctrl_reg.b_in;
	assign b_out_hs  = b_strobed && !ctrl_reg.b_in;

	// Output latches; a definition write zeroes them
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i || mode_wr)
		begin
			a_out_reg <= parallel_io_pkg::LATCH_RESET;
			b_out_reg <= parallel_io_pkg::LATCH_RESET;
		end
		else
		begin
			if (wr_a)
				a_out_reg <= bus_i.wdata;
			if (wr_b)
				b_out_reg <= bus_i.wdata;
		end
	end

	// Strobed input latches capture on the strobe's falling edge
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			a_in_reg <= parallel_io_pkg::LATCH_RESET;
			b_in_reg <= parallel_io_pkg::LATCH_RESET;
		end
		else
		begin
			if (a_in_hs && stb_a_fall)
				a_in_reg <= a_s2_reg;
			if (b_in_hs && hs_b_fall)
				b_in_reg <= b_s2_reg;
		end
	end

	// Interrupt enables ride on bit-ops to the strobe and acknowledge lines
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i || mode_wr)
		begin
			inte_a_in_reg  <= 1'b0;
			inte_a_out_reg <= 1'b0;
			inte_b_reg     <= 1'b0;
		end
		else if (bsr_wr)
		begin
			if (bsr_sel == 3'(parallel_io_pkg::PC_STB_A))
				inte_a_in_reg <= bsr_val;
			if (bsr_sel == 3'(parallel_io_pkg::PC_ACK_A))
				inte_a_out_reg <= bsr_val;
			if (bsr_sel == 3'(parallel_io_pkg::PC_STB_B))
				inte_b_reg <= bsr_val;
		end
	end

	// Port C latch holds both plain outputs and handshake status, so bit-ops
	// reach the status bits too. Host clears come first so a pin event wins.
	always_comb
	begin
		pc_next = pc_reg;
		if (wr_c)
			pc_next = bus_i.wdata;
		if (bsr_wr)
			pc_next[bsr_sel] = bsr_val;
		if (a_in_hs && rd_a)
		begin
			pc_next[parallel_io_pkg::PC_IBF_A]  = 1'b0;
			pc_next[parallel_io_pkg::PC_INTR_A] = 1'b0;
		end
		if (a_out_hs && wr_a)
		begin
			pc_next[parallel_io_pkg::PC_OBF_A]  = 1'b0;
			pc_next[parallel_io_pkg::PC_INTR_A] = 1'b0;
		end
		if ((b_in_hs && rd_b) || (b_out_hs && wr_b))
		begin
			pc_next[parallel_io_pkg::PC_HS_B]   = b_out_hs ? 1'b0 : 1'b0;
			pc_next[parallel_io_pkg::PC_INTR_B] = 1'b0;
		end
		// Handshake events from the far side
		if (a_in_hs && stb_a_fall)
			pc_next[parallel_io_pkg::PC_IBF_A] = 1'b1;
		if (a_in_hs && stb_a_rise && inte_a_in_reg)
			pc_next[parallel_io_pkg::PC_INTR_A] = 1'b1;
		if (a_out_hs && ack_a_fall)
			pc_next[parallel_io_pkg::PC_OBF_A] = 1'b1;
		if (a_out_hs && ack_a_rise && inte_a_out_reg)
			pc_next[parallel_io_pkg::PC_INTR_A] = 1'b1;
		if (b_strobed && hs_b_fall)
			pc_next[parallel_io_pkg::PC_HS_B] = 1'b1;
		if (b_strobed && hs_b_rise && inte_b_reg)
			pc_next[parallel_io_pkg::PC_INTR_B] = 1'b1;
		if (mode_wr)
			pc_next = parallel_io_pkg::LATCH_RESET;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			pc_reg <= parallel_io_pkg::LATCH_RESET;
		else
			pc_reg <= pc_next;
	end

	// Per-line drive of port C: nibble direction, then handshake roles
	always_comb
	begin
		c_drive = {{4{~ctrl_reg.cu_in}}, {4{~ctrl_reg.cl_in}}};
		if (b_strobed)
		begin
			c_drive[parallel_io_pkg::PC_INTR_B] = 1'b1;
			c_drive[parallel_io_pkg::PC_HS_B]   = 1'b1;
			c_drive[parallel_io_pkg::PC_STB_B]  = 1'b0;
		end
		unique case (a_mode)
			parallel_io_pkg::A_BASIC:
				c_drive = c_drive;
			parallel_io_pkg::A_STROBED:
			begin
				c_drive[parallel_io_pkg::PC_INTR_A] = 1'b1;
				if (ctrl_reg.a_in)
				begin
					c_drive[parallel_io_pkg::PC_STB_A] = 1'b0;
					c_drive[parallel_io_pkg::PC_IBF_A] = 1'b1;
				end
				else
				begin
					c_drive[parallel_io_pkg::PC_ACK_A] = 1'b0;
					c_drive[parallel_io_pkg::PC_OBF_A] = 1'b1;
				end
			end
			parallel_io_pkg::A_BIDIR:
			begin
				c_drive[parallel_io_pkg::PC_INTR_A] = 1'b1;
				c_drive[parallel_io_pkg::PC_STB_A]  = 1'b0;
				c_drive[parallel_io_pkg::PC_IBF_A]  = 1'b1;
				c_drive[parallel_io_pkg::PC_ACK_A]  = 1'b0;
				c_drive[parallel_io_pkg::PC_OBF_A]  = 1'b1;
			end
		endcase
	end

	// A driven line reads back its latch, so upper C as output still
	// reaches the interrupt path
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_c_line
			assign c_eff[i] = c_drive[i] ? pc_reg[i] : c_s2_reg[i];
		end
	endgenerate

	// Bus mode drives port A only while the peripheral acknowledges
	always_comb
	begin
		if (a_mode == parallel_io_pkg::A_BIDIR)
			a_drive = ~c_s2_reg[parallel_io_pkg::PC_ACK_A];
		else
			a_drive = ~ctrl_reg.a_in;
	end

	// Enables are registered; low means this side drives the line
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			pa_oe_n_o <= 8'hFF;
			pb_oe_n_o <= 8'hFF;
			pc_oe_n_o <= 8'hFF;
		end
		else
		begin
			pa_oe_n_o <= {8{~a_drive}};
			pb_oe_n_o <= {8{ctrl_reg.b_in}};
			pc_oe_n_o <= ~c_drive;
		end
	end

	assign pa_o = a_out_reg;
	assign pb_o = b_out_reg;
	assign pc_o = pc_reg;

	// Line 23 is the request, line 22 the active-low driver enable
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			irq_o      <= 1'b0;
			irq_oe_n_o <= 1'b1;
		end
		else
		begin
			irq_o      <= c_eff[parallel_io_pkg::IRQ_REQ_BIT];
			irq_oe_n_o <= c_eff[parallel_io_pkg::IRQ_EN_BIT];
		end
	end

	// Read mux: basic inputs are live, strobed inputs come from the latch
	always_comb
	begin
		unique case (bus_i.addr)
			parallel_io_pkg::OFS_PORT_A:
				rd_next = a_in_hs ? a_in_reg : (ctrl_reg.a_in ? a_s2_reg : a_out_reg);
			parallel_io_pkg::OFS_PORT_B:
				rd_next = b_in_hs ? b_in_reg : (ctrl_reg.b_in ? b_s2_reg : b_out_reg);
			parallel_io_pkg::OFS_PORT_C:
				rd_next = c_eff;
			parallel_io_pkg::OFS_CONTROL:
				rd_next = parallel_io_pkg::READ_CONTROL;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			rd_data_o  <= 8'h00;
			rd_valid_o <= 1'b0;
		end
		else
		begin
			rd_valid_o <= bus_i.rd;
			if (bus_i.rd)
				rd_data_o <= rd_next;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	reset_all_input_a: assert property ($fell(reset_i) |->
		pa_oe_n_o == 8'hFF && pb_oe_n_o == 8'hFF && pc_oe_n_o == 8'hFF)
		else $error("lines not all inputs after reset");

	example_word_a: assert property ((mode_wr && bus_i.wdata == 8'h98) ##1 !mode_wr
		|=> pa_oe_n_o == 8'hFF && pb_oe_n_o == 8'h00 && pc_oe_n_o == 8'hF0)
		else $error("control word 0x98 gives wrong directions");

	define_clears_a: assert property (mode_wr
		|=> pa_o == 8'h00 && pb_o == 8'h00 && pc_o == 8'h00)
		else $error("definition write left an output latch set");

	bit_op_a: assert property ((bsr_wr && a_mode == parallel_io_pkg::A_BASIC && !b_strobed)
		|=> pc_o[$past(bsr_sel)] == $past(bsr_val))
		else $error("bit set or clear not applied to port C");

	latch_hold_a: assert property ((!ctrl_reg.a_in && !wr_a && !mode_wr)
		|=> $stable(pa_o))
		else $error("port A output latch changed without a write");

	strobe_capture_a: assert property ((a_in_hs && stb_a_fall && !mode_wr)
		|=> pc_o[parallel_io_pkg::PC_IBF_A] && a_in_reg == $past(a_s2_reg))
		else $error("strobe did not latch port A or flag it full");

	port_c_read_a: assert property ((bus_i.rd && bus_i.addr == parallel_io_pkg::OFS_PORT_C)
		|=> rd_valid_o && rd_data_o == $past(c_eff))
		else $error("port C read does not show the line levels");

	irq_drive_a: assert property ((c_eff[7:6] == 2'b10)
		|=> irq_o && !irq_oe_n_o)
		else $error("interrupt request not driven while enabled");

	cover_example_word_c: cover property (mode_wr && bus_i.wdata == 8'h98);
	cover_strobe_in_c: cover property (a_in_hs && stb_a_fall);
	cover_bit_op_c: cover property (bsr_wr ##1 bus_i.rd);
	cover_irq_c: cover property (irq_o && !irq_oe_n_o);

endmodule

`default_nettype wire

// [dv/host_bus_model.sv]
// Host side of the port: issues one-cycle read and write strobes on the byte bus.
// Assumes the caller is clocked by the same sys_clk_i and waits for each task to end.
`timescale 1ns/100ps
`default_nettype none
module host_bus_model
(
	input  wire logic                     clk_i,
	input  wire logic [7:0]               rd_data_i,
	input  wire logic                     rd_valid_i,
	output var parallel_io_pkg::bus_req_t bus_o
);
	initial bus_o = '0;

	// Strobe is raised after one edge and taken at the next, then dropped
	task automatic bus_write(input logic [1:0] addr, input logic [7:0] data);
		@(posedge clk_i);
		bus_o <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
		@(posedge clk_i);
		bus_o <= '0;
	endtask

	// Answer is taken one edge after the strobe edge; ok reports the valid flag
	task automatic bus_read(input logic [1:0] addr, output logic [7:0] data, output logic ok);
		@(posedge clk_i);
		bus_o <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
		@(posedge clk_i);
		bus_o <= '0;
		@(posedge clk_i);
		data = rd_data_i;
		ok = rd_valid_i;
	endtask
endmodule
`default_nettype wire

// [dv/parallel_io_port_tb_top.sv]
// Self-checking bench for the parallel port: host bus calls with expected values.
// Assumes the pins are plain wires; the bench plays the external devices.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module parallel_io_port_tb_top;
	logic                      sys_clk_i;
	logic                      reset_i;
	parallel_io_pkg::bus_req_t bus;
	logic [7:0]                rd_data, pa_o, pa_oe_n, pb_o, pb_oe_n, pc_o, pc_oe_n, d;
	logic [7:0]                pa_x = 8'h00;
	logic [7:0]                pb_x = 8'h00;
	logic [7:0]                pc_x = 8'hFF;
	logic                      rd_valid, irq, irq_oe_n, ok;
	int                        error_cnt = 0;
	int                        checks_done = 0;
	int                        cycles = 0;
	// Wire level: device drives where its enable is low, the far side elsewhere
	wire  [7:0]                pa_w = (pa_x & pa_oe_n) | (pa_o & ~pa_oe_n);
	wire  [7:0]                pb_w = (pb_x & pb_oe_n) | (pb_o & ~pb_oe_n);
	wire  [7:0]                pc_w = (pc_x & pc_oe_n) | (pc_o & ~pc_oe_n);

	parallel_io_port dut
	(
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus_i(bus),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.pa_i(pa_w), .pa_o(pa_o), .pa_oe_n_o(pa_oe_n),
		.pb_i(pb_w), .pb_o(pb_o), .pb_oe_n_o(pb_oe_n),
		.pc_i(pc_w), .pc_o(pc_o), .pc_oe_n_o(pc_oe_n),
		.irq_o(irq), .irq_oe_n_o(irq_oe_n)
	);

	host_bus_model host
	(
		.clk_i(sys_clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .bus_o(bus)
	);

	initial
	begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic rd_chk(input logic [1:0] a, input logic [7:0] e, input string nm);
		host.bus_read(a, d, ok);
		`CHK("read valid", 1'b1, ok)
		`CHK(nm, e, d)
	endtask

	task automatic ctl(input logic [7:0] w);
		host.bus_write(2'h3, w);
		cyc(2);
	endtask

	task automatic tend(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Whole run needs about 300 cycles; the ceiling leaves wide margin
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles > 20000)
		begin
			error_cnt++;
			finish_test();
		end
	end

	initial
	begin
		reset_i = 1'b1;
		repeat (12) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		cyc(1);
		`CHK("oe a", 8'hFF, pa_oe_n)
		`CHK("oe b", 8'hFF, pb_oe_n)
		`CHK("oe c", 8'hFF, pc_oe_n)
		rd_chk(2'h3, 8'h00, "ctrl");
		tend("reset");

		ctl(8'h98);
		`CHK("oe a", 8'hFF, pa_oe_n)
		`CHK("oe b", 8'h00, pb_oe_n)
		`CHK("oe c", 8'hF0, pc_oe_n)
		@(posedge sys_clk_i) pa_x <= 8'h5A;
		pc_x <= 8'h3C;
		host.bus_write(2'h1, 8'hFF);
		host.bus_write(2'h2, 8'h0F);
		cyc(2);
		`CHK("b pins", 8'hFF, pb_o)
		rd_chk(2'h0, 8'h5A, "a live");
		rd_chk(2'h2, 8'h3F, "c mixed");
		rd_chk(2'h1, 8'hFF, "b latch");
		@(posedge sys_clk_i) pa_x <= 8'hA5;
		cyc(4);
		rd_chk(2'h0, 8'hA5, "a live again");
		ctl(8'h98);
		`CHK("b cleared", 8'h00, pb_o)
		tend("basic");

		for (int i = 0; i < 16; i++)
		begin
			ctl({3'b100, i[3:2], 1'b0, i[1:0]});
			`CHK("combo a", {8{i[3]}}, pa_oe_n)
			`CHK("combo b", {8{i[1]}}, pb_oe_n)
			`CHK("combo c", {{4{i[2]}}, {4{i[0]}}}, pc_oe_n)
		end
		tend("directions");

		ctl(8'h80);
		for (int b = 0; b < 8; b++)
		begin
			ctl({4'h7, b[2:0], 1'b1});
			`CHK("bit set", 8'hFF >> (7 - b), pc_o)
		end
		for (int b = 0; b < 8; b++)
		begin
			ctl({4'h0, b[2:0], 1'b0});
			`CHK("bit clear", 8'hFE << b, pc_o)
		end
		tend("bit ops");

		ctl(8'h0F);
		cyc(3);
		`CHK("irq", 1'b1, irq)
		`CHK("irq en", 1'b0, irq_oe_n)
		rd_chk(2'h2, 8'h80, "c irq");
		ctl(8'h88);
		@(posedge sys_clk_i) pc_x <= 8'h40;
		cyc(5);
		`CHK("irq in", 1'b0, irq)
		`CHK("irq en in", 1'b1, irq_oe_n)
		rd_chk(2'h2, 8'h40, "c irq in");
		tend("interrupt");

		@(posedge sys_clk_i) pc_x <= 8'hFF;
		ctl(8'hB8);
		ctl(8'h09);
		@(posedge sys_clk_i) pa_x <= 8'h3C;
		pc_x[4] <= 1'b0;
		cyc(5);
		`CHK("in full", 1'b1, pc_o[5])
		@(posedge sys_clk_i) pa_x <= 8'hC3;
		pc_x[4] <= 1'b1;
		cyc(5);
		`CHK("in intr", 1'b1, pc_o[3])
		rd_chk(2'h0, 8'h3C, "a held");
		cyc(1);
		`CHK("full clr", 1'b0, pc_o[5])
		`CHK("intr clr", 1'b0, pc_o[3])
		tend("strobed in");

		ctl(8'hA8);
		`CHK("obf def", 1'b0, pc_o[7])
		ctl(8'h0F);
		`CHK("obf bitop", 1'b1, pc_o[7])
		host.bus_write(2'h0, 8'h55);
		cyc(2);
		`CHK("a out", 8'h55, pa_o)
		`CHK("obf set", 1'b0, pc_o[7])
		@(posedge sys_clk_i) pc_x[6] <= 1'b0;
		cyc(5);
		`CHK("obf ack", 1'b1, pc_o[7])
		@(posedge sys_clk_i) pc_x[6] <= 1'b1;
		tend("strobed out");

		// Strobe line sits low while driven by the old mode; let the release
		// edge pass before the interrupt enable is set
		ctl(8'h86);
		cyc(3);
		ctl(8'h05);
		`CHK("b hs oe", 8'h04, pc_oe_n)
		@(posedge sys_clk_i) pb_x <= 8'h6C;
		pc_x[2] <= 1'b0;
		cyc(5);
		`CHK("b full", 1'b1, pc_o[1])
		@(posedge sys_clk_i) pb_x <= 8'h00;
		pc_x[2] <= 1'b1;
		cyc(5);
		`CHK("b intr", 1'b1, pc_o[0])
		rd_chk(2'h1, 8'h6C, "b held");
		cyc(1);
		`CHK("b full clr", 1'b0, pc_o[1])
		`CHK("b intr clr", 1'b0, pc_o[0])
		tend("strobed b");

		ctl(8'hC8);
		host.bus_write(2'h0, 8'h77);
		cyc(5);
		`CHK("bus idle", 8'hFF, pa_oe_n)
		@(posedge sys_clk_i) pc_x[6] <= 1'b0;
		cyc(5);
		`CHK("bus drive", 8'h00, pa_oe_n)
		`CHK("bus data", 8'h77, pa_o)
		// The port keeps driving until the acknowledge release is synchronised,
		// so the peripheral only strobes its data once the bus is free
		@(posedge sys_clk_i) pc_x[6] <= 1'b1;
		cyc(5);
		`CHK("bus release", 8'hFF, pa_oe_n)
		@(posedge sys_clk_i) pa_x <= 8'h99;
		pc_x[4] <= 1'b0;
		cyc(5);
		`CHK("bus full", 1'b1, pc_o[5])
		@(posedge sys_clk_i) pc_x[4] <= 1'b1;
		pa_x <= 8'h11;
		cyc(5);
		rd_chk(2'h0, 8'h99, "bus in");
		tend("bidirectional");
		finish_test();
	end
endmodule
`default_nettype wire
